/* File: hdl/rmpu_pkg.sv */
// constants, types and attribute decoders for the region memory protection unit
package rmpu_pkg;
    localparam int unsigned NUM_REGIONS = 8;

    // register byte addresses
    localparam logic [31:0] OFF_CAPABILITY   = 32'he000ed90;
    localparam logic [31:0] OFF_CONTROL      = 32'he000ed94;
    localparam logic [31:0] OFF_SELECT       = 32'he000ed98;
    localparam logic [31:0] OFF_BASE         = 32'he000ed9c;
    localparam logic [31:0] OFF_ATTR         = 32'he000eda0;
    localparam logic [31:0] OFF_BASE_ALIAS1  = 32'he000eda4;
    localparam logic [31:0] OFF_ATTR_ALIAS1  = 32'he000eda8;
    localparam logic [31:0] OFF_BASE_ALIAS2  = 32'he000edac;
    localparam logic [31:0] OFF_ATTR_ALIAS2  = 32'he000edb0;
    localparam logic [31:0] OFF_BASE_ALIAS3  = 32'he000edb4;
    localparam logic [31:0] OFF_ATTR_ALIAS3  = 32'he000edb8;

    // reset values
    localparam logic [31:0] RST_CAPABILITY   = 32'h00000800;
    localparam logic [31:0] RST_ZERO         = 32'h00000000;

    // field positions
    localparam int unsigned CAP_INSTR_LSB    = 16;
    localparam int unsigned CAP_DATA_LSB     = 8;
    localparam int unsigned CTRL_ENABLE_BIT  = 0;
    localparam int unsigned CTRL_HIPRI_BIT   = 1;
    localparam int unsigned CTRL_PRIVBG_BIT  = 2;
    localparam logic [31:0] CTRL_WRITE_MASK  = 32'h00000007;
    localparam int unsigned BASE_ADDR_LSB    = 5;
    localparam int unsigned BASE_VALID_BIT   = 4;
    localparam int unsigned ATTR_ENABLE_BIT  = 0;
    localparam int unsigned ATTR_SIZE_LSB    = 1;
    localparam int unsigned ATTR_SUBOFF_LSB  = 8;
    localparam int unsigned ATTR_BUFFER_BIT  = 16;
    localparam int unsigned ATTR_CACHE_BIT   = 17;
    localparam int unsigned ATTR_SHARE_BIT   = 18;
    localparam int unsigned ATTR_CLASS_LSB   = 19;
    localparam int unsigned ATTR_PERM_LSB    = 24;
    localparam int unsigned ATTR_NOEXEC_BIT  = 28;
    localparam logic [31:0] ATTR_WRITE_MASK  = 32'h173fff3f;
    localparam logic [19:0] SYSCTL_PAGE      = 20'he000e;

    typedef enum logic [1:0] {RMPU_STRONG, RMPU_DEVICE, RMPU_NORMAL} rmpu_memtype_t;
    typedef enum logic [1:0] {RMPU_NC, RMPU_WT, RMPU_WB} rmpu_cache_t;
    typedef struct packed {
        rmpu_memtype_t memType;
        logic          shared;
        rmpu_cache_t   cache;
    } rmpu_attr_t;

    function automatic rmpu_attr_t rmpu_decode_attr(logic [2:0] cls, logic c, logic b, logic s);
        rmpu_attr_t a;
        a = '{RMPU_NORMAL, s, RMPU_NC};
        case ({cls, c, b})
            5'h00:   a = '{RMPU_STRONG, 1'b1, RMPU_NC};
            5'h01:   a = '{RMPU_DEVICE, 1'b1, RMPU_NC};
            5'h08:   a = '{RMPU_DEVICE, 1'b0, RMPU_NC};
            5'h02:   a = '{RMPU_NORMAL, s, RMPU_WT};
            5'h03:   a = '{RMPU_NORMAL, s, RMPU_WB};
            5'h07:   a = '{RMPU_NORMAL, s, RMPU_WB};
            default: a = '{RMPU_NORMAL, s, RMPU_NC};
        endcase
        return a;
    endfunction

    // attributes of the unprotected map, by 512 MB segment
    function automatic rmpu_attr_t rmpu_default_attr(logic [2:0] seg);
        rmpu_attr_t a;
        case (seg)
            3'h0:    a = '{RMPU_NORMAL, 1'b0, RMPU_WT};
            3'h1:    a = '{RMPU_NORMAL, 1'b0, RMPU_WB};
            3'h2:    a = '{RMPU_DEVICE, 1'b0, RMPU_NC};
            3'h3:    a = '{RMPU_NORMAL, 1'b0, RMPU_WB};
            3'h4:    a = '{RMPU_NORMAL, 1'b0, RMPU_WT};
            3'h5:    a = '{RMPU_DEVICE, 1'b1, RMPU_NC};
            3'h6:    a = '{RMPU_DEVICE, 1'b0, RMPU_NC};
            default: a = '{RMPU_STRONG, 1'b1, RMPU_NC};
        endcase
        return a;
    endfunction

    function automatic logic [31:0] rmpu_merge(logic [31:0] old, logic [31:0] wr, logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[i*8 +: 8] = wr[i*8 +: 8];
            end
        end
        return m;
    endfunction
endpackage

/* File: hdl/rmpu_region_if.sv */
// one region's settings and the address under test, with its match answer
`timescale 1ns/100ps
interface rmpu_region_if;
    logic [31:0] addr;
    logic [31:0] base;
    logic [31:0] attr;
    logic        hit;
    modport owner (output addr, output base, output attr, input hit);
    modport check (input addr, input base, input attr, output hit);
endinterface

/* File: hdl/rmpu_region_check.sv */
// size-aligned address match of one region, with subregion disables
`timescale 1ns/100ps
module rmpu_region_check (
    // region settings and access address
    rmpu_region_if.check rg
);
    logic [5:0]  sizeLog;
    logic [32:0] span;
    logic [31:0] lowMask;
    logic [31:0] shifted;
    logic [2:0]  subIdx;
    logic        subOff;
    logic        inRange;

    // region covers 2^(size+1) bytes
    assign sizeLog = 6'(rg.attr[rmpu_pkg::ATTR_SIZE_LSB +: 5]) + 6'h01;
    assign span    = 33'h1 << sizeLog;
    assign lowMask = span[31:0] - 32'h1;
    assign inRange = ((rg.addr ^ rg.base) & ~lowMask) == 32'h0;
    assign shifted = rg.addr >> (sizeLog - 6'h03);
    assign subIdx  = shifted[2:0];
    // regions below 256 bytes have no subregions
    assign subOff  = (sizeLog >= 6'h08) ? rg.attr[rmpu_pkg::ATTR_SUBOFF_LSB + subIdx] : 1'b0;
    assign rg.hit  = rg.attr[rmpu_pkg::ATTR_ENABLE_BIT] & inRange & ~subOff;
endmodule

/* File: hdl/rmpu_unit.sv */
// region memory protection unit: region registers, Wishbone slave, access check
//
// Contract
// - eight configurable regions, numbered 0 to 7, plus one background region
// - overlapping hits take attributes of the highest-numbered matching region
// - background region uses default map attributes, privileged accesses only
// - fetches and data accesses share one region map
// - prohibited access is blocked and raises a memory management fault
// - resolved memory type, shareability and cache policy exported per access
// - strongly-ordered regions always reported shared, accesses kept in order
// - device regions shared or non-shared only, no cache policy
// - normal regions shared or not, with non-cacheable, write-through or write-back
// - three aliases act exactly as the base address register
// - three aliases act exactly as the attribute and size register
// - capability register reports zero instruction regions
// - capability register reports eight data regions
// - capability bit zero reads zero: unified map
// - registers reached only by privileged accesses, all but capability reset to zero
// - unit disabled: every access uses the default map attributes
// - enabled with background bit: privileged misses and system control page accesses use default map, other misses fault
// - checking suspended at priority -1 or -2 unless high-priority bit set
// - base write with valid bit loads region select first, else uses selection
`timescale 1ns/100ps
module rmpu_unit #(
    parameter int unsigned NUM_REGIONS = rmpu_pkg::NUM_REGIONS
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // wishbone register slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [31:0] wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatI,
    input  wire logic        busPriv,
    output logic      [31:0] wbDatO,
    output logic             wbAck,
    // access request from the core
    input  wire logic        accValid,
    input  wire logic [31:0] accAddr,
    input  wire logic        accFetch,
    input  wire logic        accWrite,
    input  wire logic        accPriv,
    input  wire logic        accEscalated,
    // checked access answer
    output logic             respValid,
    output logic             respFault,
    output logic      [1:0]  respMemType,
    output logic             respShared,
    output logic      [1:0]  respCache,
    output logic             respHit,
    output logic      [2:0]  respRegion
);
    localparam int unsigned IDX_W = $clog2(NUM_REGIONS);

    logic [2:0]       ctrl;
    logic [7:0]       regionSelect;
    logic [31:0]      baseReg [NUM_REGIONS];
    logic [31:0]      attrReg [NUM_REGIONS];
    logic [NUM_REGIONS-1:0] hit;

    logic             busReq;
    logic             wrEn;
    logic             isBase;
    logic             isAttr;
    logic [IDX_W-1:0] selIdx;
    logic             selOk;
    logic [31:0]      rdVal;
    logic [31:0]      baseWord;
    logic [31:0]      attrWord;
    logic             baseValid;
    logic [7:0]       baseTarget;

    logic             winHit;
    logic [IDX_W-1:0] winIdx;
    logic             checkOn;
    logic             inSysCtl;
    logic             permit;
    rmpu_pkg::rmpu_attr_t winAttr;
    rmpu_pkg::rmpu_attr_t defAttr;
    rmpu_pkg::rmpu_attr_t next_attr;
    logic             next_fault;
    logic             next_hit;

    // ---------------- register bus ----------------
    assign busReq = wbCyc & wbStb & ~wbAck;
    // unprivileged bus accesses are answered but neither write nor read
    assign wrEn   = busReq & wbWe & busPriv;
    assign isBase = (wbAdr == rmpu_pkg::OFF_BASE) || (wbAdr == rmpu_pkg::OFF_BASE_ALIAS1) ||
                    (wbAdr == rmpu_pkg::OFF_BASE_ALIAS2) || (wbAdr == rmpu_pkg::OFF_BASE_ALIAS3);
    assign isAttr = (wbAdr == rmpu_pkg::OFF_ATTR) || (wbAdr == rmpu_pkg::OFF_ATTR_ALIAS1) ||
                    (wbAdr == rmpu_pkg::OFF_ATTR_ALIAS2) || (wbAdr == rmpu_pkg::OFF_ATTR_ALIAS3);
    assign selIdx = regionSelect[IDX_W-1:0];
    assign selOk  = regionSelect < 8'(NUM_REGIONS);

    assign baseValid  = wbSel[0] & wbDatI[rmpu_pkg::BASE_VALID_BIT];
    // the valid bit retargets the write before the base is stored
    assign baseTarget = baseValid ? {4'h0, wbDatI[3:0]} : regionSelect;
    assign baseWord   = rmpu_pkg::rmpu_merge(baseReg[baseTarget[IDX_W-1:0]], wbDatI, wbSel)
                        & ~32'((64'h1 << rmpu_pkg::BASE_ADDR_LSB) - 64'h1);
    assign attrWord   = rmpu_pkg::rmpu_merge(attrReg[selIdx], wbDatI, wbSel) & rmpu_pkg::ATTR_WRITE_MASK;

    always_comb begin
        rdVal = rmpu_pkg::RST_ZERO;
        if (isBase) begin
            if (selOk) begin
                rdVal = baseReg[selIdx];
            end
            // valid reads zero, region field mirrors the selection
            rdVal[3:0] = regionSelect[3:0];
        end else if (isAttr) begin
            if (selOk) begin
                rdVal = attrReg[selIdx];
            end
        end else begin
            case (wbAdr)
                rmpu_pkg::OFF_CAPABILITY: rdVal = rmpu_pkg::RST_CAPABILITY;
                rmpu_pkg::OFF_CONTROL:    rdVal = {29'h0, ctrl};
                rmpu_pkg::OFF_SELECT:     rdVal = {24'h0, regionSelect};
                default:                  rdVal = rmpu_pkg::RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= busReq;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wbDatO <= rmpu_pkg::RST_ZERO;
        end else if (busReq && !wbWe) begin
            wbDatO <= busPriv ? rdVal : rmpu_pkg::RST_ZERO;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= 3'h0;
        end else if (wrEn && wbAdr == rmpu_pkg::OFF_CONTROL) begin
            ctrl <= 3'(rmpu_pkg::rmpu_merge({29'h0, ctrl}, wbDatI, wbSel) & rmpu_pkg::CTRL_WRITE_MASK);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            regionSelect <= 8'h00;
        end else if (wrEn && wbAdr == rmpu_pkg::OFF_SELECT) begin
            regionSelect <= 8'(rmpu_pkg::rmpu_merge({24'h0, regionSelect}, wbDatI, wbSel));
        end else if (wrEn && isBase && baseValid) begin
            regionSelect <= {4'h0, wbDatI[3:0]};
        end
    end

    // out-of-range selections are ignored rather than aliased onto a region
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_REGIONS; i++) begin
                baseReg[i] <= rmpu_pkg::RST_ZERO;
                attrReg[i] <= rmpu_pkg::RST_ZERO;
            end
        end else if (wrEn && isBase && baseTarget < 8'(NUM_REGIONS)) begin
            baseReg[baseTarget[IDX_W-1:0]] <= baseWord;
        end else if (wrEn && isAttr && selOk) begin
            attrReg[selIdx] <= attrWord;
        end
    end

    // ---------------- region match ----------------
    // one map serves fetch and data alike
    generate
        for (genvar g = 0; g < NUM_REGIONS; g++) begin : gRegion
            rmpu_region_if rif ();
            assign rif.addr = accAddr;
            assign rif.base = baseReg[g];
            assign rif.attr = attrReg[g];
            assign hit[g]   = rif.hit;
            rmpu_region_check uCheck (
                .rg (rif.check)
            );
        end
    endgenerate

    always_comb begin
        winHit = 1'b0;
        winIdx = '0;
        for (int i = 0; i < NUM_REGIONS; i++) begin
            if (hit[i]) begin
                winHit = 1'b1;
                winIdx = IDX_W'(i);
            end
        end
    end

    assign checkOn = ctrl[rmpu_pkg::CTRL_ENABLE_BIT] &
                     ~(accEscalated & ~ctrl[rmpu_pkg::CTRL_HIPRI_BIT]);
    assign inSysCtl = accAddr[31:12] == rmpu_pkg::SYSCTL_PAGE;
    assign defAttr = rmpu_pkg::rmpu_default_attr(accAddr[31:29]);
    assign winAttr = rmpu_pkg::rmpu_decode_attr(attrReg[winIdx][rmpu_pkg::ATTR_CLASS_LSB +: 3],
                                                attrReg[winIdx][rmpu_pkg::ATTR_CACHE_BIT],
                                                attrReg[winIdx][rmpu_pkg::ATTR_BUFFER_BIT],
                                                attrReg[winIdx][rmpu_pkg::ATTR_SHARE_BIT]);

    // access permission of the winning region
    always_comb begin
        logic [2:0] perm;
        perm = attrReg[winIdx][rmpu_pkg::ATTR_PERM_LSB +: 3];
        case (perm)
            3'h1:    permit = accPriv;
            3'h2:    permit = accPriv | ~accWrite;
            3'h3:    permit = 1'b1;
            3'h5:    permit = accPriv & ~accWrite;
            3'h6:    permit = ~accWrite;
            3'h7:    permit = ~accWrite;
            default: permit = 1'b0;
        endcase
        if (accFetch && attrReg[winIdx][rmpu_pkg::ATTR_NOEXEC_BIT]) begin
            permit = 1'b0;
        end
    end

    always_comb begin
        next_attr  = defAttr;
        next_fault = 1'b0;
        next_hit   = 1'b0;
        if (!checkOn) begin
            next_attr = defAttr;
        end else if (inSysCtl) begin
            next_attr = defAttr;
        end else if (winHit) begin
            next_attr  = winAttr;
            next_hit   = 1'b1;
            next_fault = ~permit;
        end else if (ctrl[rmpu_pkg::CTRL_PRIVBG_BIT] && accPriv) begin
            next_attr = defAttr;
        end else begin
            next_fault = 1'b1;
        end
    end

    // answer one cycle after the request; strongly-ordered stays in order by this fixed latency
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            respValid   <= 1'b0;
            respFault   <= 1'b0;
            respMemType <= 2'h0;
            respShared  <= 1'b0;
            respCache   <= 2'h0;
            respHit     <= 1'b0;
            respRegion  <= 3'h0;
        end else begin
            respValid   <= accValid;
            respFault   <= accValid & next_fault;
            respMemType <= next_attr.memType;
            respShared  <= next_attr.shared | (next_attr.memType == rmpu_pkg::RMPU_STRONG);
            respCache   <= next_attr.cache;
            respHit     <= accValid & next_hit;
            respRegion  <= 3'(winIdx);
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic capRead;
    assign capRead = busReq && !wbWe && busPriv && wbAdr == rmpu_pkg::OFF_CAPABILITY;

    property p_cap_instr;
        capRead |=> wbAck && wbDatO[23:16] == 8'h00;
    endproperty
    a_cap_instr: assert property (p_cap_instr) else $error("instruction region count not zero");

    property p_cap_data;
        capRead |=> wbDatO[15:8] == 8'h08;
    endproperty
    a_cap_data: assert property (p_cap_data) else $error("data region count not eight");

    property p_cap_unified;
        capRead |=> !wbDatO[0];
    endproperty
    a_cap_unified: assert property (p_cap_unified) else $error("map not reported unified");

    property p_disabled_free;
        accValid && !ctrl[0] |=> respValid && !respFault && !respHit;
    endproperty
    a_disabled_free: assert property (p_disabled_free) else $error("fault while unit disabled");

    property p_escalated_free;
        accValid && accEscalated && !ctrl[1] |=> !respFault;
    endproperty
    a_escalated_free: assert property (p_escalated_free) else $error("fault in escalated handler");

    property p_unpriv_miss;
        accValid && checkOn && !accPriv && !winHit && !inSysCtl |=> respFault;
    endproperty
    a_unpriv_miss: assert property (p_unpriv_miss) else $error("unprivileged miss not faulted");

    property p_priv_miss;
        accValid && checkOn && accPriv && !winHit && !inSysCtl |=> respFault == !$past(ctrl[2]);
    endproperty
    a_priv_miss: assert property (p_priv_miss) else $error("privileged miss handled wrongly");

    property p_highest_wins;
        accValid && checkOn && !inSysCtl && hit[NUM_REGIONS-1] |=> respHit && respRegion == 3'h7;
    endproperty
    a_highest_wins: assert property (p_highest_wins) else $error("top region did not win");

    property p_strong_shared;
        respValid && respMemType == rmpu_pkg::RMPU_STRONG |-> respShared;
    endproperty
    a_strong_shared: assert property (p_strong_shared) else $error("strongly-ordered not shared");

    property p_device_nocache;
        respValid && respMemType == rmpu_pkg::RMPU_DEVICE |-> respCache == rmpu_pkg::RMPU_NC;
    endproperty
    a_device_nocache: assert property (p_device_nocache) else $error("device region cached");

    property p_base_select;
        wrEn && isBase && baseValid |=> regionSelect == {4'h0, $past(wbDatI[3:0])};
    endproperty
    a_base_select: assert property (p_base_select) else $error("valid base write kept selection");

    property p_ack_single;
        wbAck |=> !wbAck;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

    property p_fetch_noexec;
        accValid && checkOn && !inSysCtl && winHit && accFetch &&
        attrReg[winIdx][rmpu_pkg::ATTR_NOEXEC_BIT] |=> respFault;
    endproperty
    a_fetch_noexec: assert property (p_fetch_noexec) else $error("no-execute fetch passed");

    c_fault:     cover property (accValid ##1 respFault);
    c_hit:       cover property (accValid && checkOn ##1 respHit && !respFault);
    c_alias_wr:  cover property (wrEn && wbAdr == rmpu_pkg::OFF_BASE_ALIAS3 && baseValid);
    c_overlap:   cover property (accValid && checkOn && hit[0] && hit[NUM_REGIONS-1]);
endmodule

/* File: dv/rmpu_core_model.sv */
// core-side access model: issues one checked access and captures the answer
`timescale 1ns/100ps
module rmpu_core_model (
    // clock
    input  wire logic        sys_clk,
    // access request
    output logic             accValid,
    output logic      [31:0] accAddr,
    output logic             accFetch,
    output logic             accWrite,
    output logic             accPriv,
    output logic             accEscalated,
    // checked answer
    input  wire logic        respValid,
    input  wire logic        respFault,
    input  wire logic [1:0]  respMemType,
    input  wire logic        respShared,
    input  wire logic [1:0]  respCache,
    input  wire logic        respHit,
    input  wire logic [2:0]  respRegion
);
    logic [9:0] got;
    logic       gotOk;

    initial begin
        accValid = 1'b0;
        accAddr = 32'h0;
        {accFetch, accWrite, accPriv, accEscalated} = 4'h0;
    end

    // f = {fetch, write, priv, escalated}; one access, answer one cycle later
    task automatic access(input logic [31:0] a, input logic [3:0] f);
        @(posedge sys_clk);
        accValid <= 1'b1;
        accAddr <= a;
        {accFetch, accWrite, accPriv, accEscalated} <= f;
        @(posedge sys_clk);
        accValid <= 1'b0;
        // idle address flips so a stale value never looks valid
        accAddr <= ~a;
        #1;
        gotOk = respValid;
        got = {respFault, respMemType, respShared, respCache, respHit, respRegion};
    endtask
endmodule

/* File: dv/region_memory_protection_unit_bench.sv */
// self-checking bench for the region memory protection unit
`timescale 1ns/100ps
module region_memory_protection_unit_bench;
    logic        sys_clk, rstn, wbCyc, wbStb, wbWe, busPriv, wbAck;
    logic        accValid, accFetch, accWrite, accPriv, accEscalated;
    logic        respValid, respFault, respShared, respHit;
    logic [1:0]  respMemType, respCache;
    logic [2:0]  respRegion;
    logic [3:0]  wbSel;
    logic [31:0] wbAdr, wbDatI, wbDatO, accAddr, rd;
    int          num_errors, num_checks, cycles;

    rmpu_unit rmpu_unit_inst (.sys_clk(sys_clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .busPriv(busPriv), .wbDatO(wbDatO), .wbAck(wbAck),
        .accValid(accValid), .accAddr(accAddr), .accFetch(accFetch), .accWrite(accWrite), .accPriv(accPriv),
        .accEscalated(accEscalated), .respValid(respValid), .respFault(respFault), .respMemType(respMemType),
        .respShared(respShared), .respCache(respCache), .respHit(respHit), .respRegion(respRegion));

    rmpu_core_model rmpu_core_model_inst (.sys_clk(sys_clk), .accValid(accValid), .accAddr(accAddr),
        .accFetch(accFetch), .accWrite(accWrite), .accPriv(accPriv), .accEscalated(accEscalated),
        .respValid(respValid), .respFault(respFault), .respMemType(respMemType), .respShared(respShared),
        .respCache(respCache), .respHit(respHit), .respRegion(respRegion));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic fail(input string msg);
        num_errors++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) fail(msg);
    endtask

    // classic single wishbone cycle; read data lands in rd
    // waits for ack with no cycle limit of its own; the run timeout ends a hang
    task automatic wb_cycle(input logic we, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, we, a, d};
        do begin
            @(posedge sys_clk);
        end while (wbAck !== 1'b1);
        rd = wbDatO;
        {wbCyc, wbStb, wbWe} <= 3'b000;
    endtask

    // answer bits: fault, type[2], shared, cache[2], hit, region[3]
    task automatic check_acc(input logic [31:0] a, input logic [3:0] f, input logic [9:0] exp, input logic [9:0] m);
        rmpu_core_model_inst.access(a, f);
        check_val({31'h0, rmpu_core_model_inst.gotOk}, 32'h1, "access not answered");
        check_val({22'h0, rmpu_core_model_inst.got & m}, {22'h0, exp & m}, "access answer");
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail("run timed out");
            stop_test();
        end
    end

    initial begin
        {rstn, wbCyc, wbStb, wbWe, wbAdr, wbDatI, busPriv} = '0;
        wbSel = 4'hf;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        busPriv <= 1'b1;
        wb_cycle(1'b1, rmpu_pkg::OFF_CAPABILITY, 32'hffffffff);
        wb_cycle(1'b0, rmpu_pkg::OFF_CAPABILITY, 32'h0);
        check_val(rd, 32'h00000800, "capability value");
        for (int i = 0; i < 11; i++) begin
            wb_cycle(1'b0, rmpu_pkg::OFF_CONTROL + 32'(4 * i), 32'h0);
            check_val(rd, 32'h0, "reset or unmapped value");
        end
        busPriv <= 1'b0;
        wb_cycle(1'b1, rmpu_pkg::OFF_CONTROL, 32'h7);
        busPriv <= 1'b1;
        wb_cycle(1'b0, rmpu_pkg::OFF_CONTROL, 32'h0);
        check_val(rd, 32'h0, "unprivileged write took");
        $display("test registers done");
        // region 0: 64 KB normal shared write-back full access; region 1: 1 KB strongly-ordered priv only
        wb_cycle(1'b1, rmpu_pkg::OFF_BASE, 32'h20000010);
        wb_cycle(1'b1, rmpu_pkg::OFF_ATTR, 32'h0307001f);
        wb_cycle(1'b1, rmpu_pkg::OFF_BASE_ALIAS1, 32'h20000011);
        wb_cycle(1'b1, rmpu_pkg::OFF_ATTR_ALIAS1, 32'h01000013);
        wb_cycle(1'b0, rmpu_pkg::OFF_SELECT, 32'h0);
        check_val(rd, 32'h1, "select after valid base write");
        wb_cycle(1'b0, rmpu_pkg::OFF_BASE_ALIAS2, 32'h0);
        check_val(rd, 32'h20000001, "base alias readback");
        wb_cycle(1'b0, rmpu_pkg::OFF_ATTR, 32'h0);
        check_val(rd, 32'h01000013, "attribute alias readback");
        check_acc(32'h20000000, 4'b0000, 10'h120, 10'h3f8);
        wb_cycle(1'b1, rmpu_pkg::OFF_CONTROL, 32'h1);
        check_acc(32'h20000000, 4'b0000, 10'h200, 10'h200);
        check_acc(32'h20000000, 4'b0010, 10'h049, 10'h3ff);
        check_acc(32'h20000800, 4'b1000, 10'h168, 10'h3ff);
        check_acc(32'h40000000, 4'b0010, 10'h200, 10'h200);
        $display("test regions done");
        wb_cycle(1'b1, rmpu_pkg::OFF_CONTROL, 32'h5);
        check_acc(32'h40000000, 4'b0010, 10'h080, 10'h3f8);
        check_acc(32'h40000000, 4'b0000, 10'h200, 10'h200);
        check_acc(32'h20000000, 4'b0001, 10'h120, 10'h3f8);
        wb_cycle(1'b1, rmpu_pkg::OFF_CONTROL, 32'h7);
        check_acc(32'h20000000, 4'b0001, 10'h200, 10'h200);
        $display("test background done");
        // region 7: 256 B device shared, no-execute, full access, subregion 1 disabled
        wb_cycle(1'b1, rmpu_pkg::OFF_BASE_ALIAS3, 32'h20000017);
        wb_cycle(1'b1, rmpu_pkg::OFF_ATTR_ALIAS3, 32'h1301020f);
        check_acc(32'h20000000, 4'b0000, 10'h0cf, 10'h3ff);
        check_acc(32'h20000020, 4'b0000, 10'h249, 10'h3ff);
        check_acc(32'h20000000, 4'b1010, 10'h2cf, 10'h3ff);
        $display("test overlap done");
        stop_test();
    end
endmodule
